/* File: hw/ddly_sync_pkg.sv */
// constants, register map and field layout for the dynamic digital delay alignment block
// What this block does
// - half step bit gives half-cycle delay granularity
// - half step change applies at once
// - delay count applies only at an alignment
// - feedback select picks the qualifying output
// - exempt outputs keep toggling through alignment
// - exempt qualifier absolute, otherwise relative mode
// - auto mode: write R0..starts alignment
// - one-shot starts 3 cycles after qualification, lasts 3
// - one-shot stops outputs then restarts them
// - absolute mode leaves qualifier half step alone
// - glitch possible when output forced low
// - one cycle is one distribution clock period
// - aligned outputs held low, exempt untouched
// - qualified: low 5 after start, rise 5 plus delay after end; unqualified: 7 and 7 plus delay
package ddly_sync_pkg;

  localparam int unsigned NUM_OUTPUTS = 6;
  localparam int unsigned DIV_W       = 8;
  localparam int unsigned DDLY_W      = 5;
  localparam int unsigned SEL_W       = 3;

  // per-output registers R0..one word each
  localparam logic [7:0] OUT_REG0_ADDR = 8'h00;
  localparam logic [7:0] OUT_REG5_ADDR = 8'h14;
  localparam logic [7:0] CONFIG_ADDR   = 8'h18;
  localparam logic [7:0] STATUS_ADDR   = 8'h1C;

  // output register fields
  localparam int unsigned DIV_LSB        = 0;
  localparam int unsigned DDLY_LSB       = 8;
  localparam int unsigned HALF_STEP_BIT  = 13;
  localparam int unsigned EXEMPT_BIT     = 14;
  localparam int unsigned POWER_DOWN_BIT = 15;

  // configuration register fields
  localparam int unsigned QUAL_EN_BIT    = 0;
  localparam int unsigned FB_EN_BIT      = 1;
  localparam int unsigned AUTO_BIT       = 2;
  localparam int unsigned POL_INV_BIT    = 3;
  localparam int unsigned FB_SEL_LSB     = 4;

  // status register fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_ABS_BIT     = 1;
  localparam int unsigned ST_FORCE_BIT   = 2;
  localparam int unsigned ST_CLK_LSB     = 8;

  // reset values
  localparam logic [DIV_W-1:0]  DIV_RESET  = 8'h02;
  localparam logic [DDLY_W-1:0] DDLY_RESET = 5'h05;
  localparam logic [31:0]       CONFIG_RESET = 32'h0000_0000;

  // alignment timing, in distribution clock cycles
  localparam int unsigned QUAL_EDGES     = 2;
  localparam int unsigned LEAD_CYCLES    = 3;
  localparam int unsigned ONESHOT_CYCLES = 3;
  localparam int unsigned FORCE_LAG_Q    = 5;
  localparam int unsigned FORCE_LAG_UNQ  = 6;

  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_QUAL,
    ALIGN_LEAD,
    ALIGN_PULSE
  } align_state_t;

  typedef enum logic [1:0] {
    CH_RUN,
    CH_HELD,
    CH_DELAY
  } chan_state_t;

endpackage

/* File: hw/out_channel.sv */
// one divided clock output with forced-low hold and restart delay
module out_channel (
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic [ddly_sync_pkg::DIV_W-1:0]  divide_i,
  input  wire logic [ddly_sync_pkg::DDLY_W-1:0] delay_i,
  input  wire logic                             exempt_i,
  input  wire logic                             power_down_i,
  input  wire logic                             force_low_i,
  output logic                                  clk_o
);

  ddly_sync_pkg::chan_state_t            state_q;
  logic [ddly_sync_pkg::DIV_W-1:0]       cnt_q;
  logic [ddly_sync_pkg::DDLY_W-1:0]      dly_q;
  logic                                  hold;
  logic [ddly_sync_pkg::DIV_W-1:0]       half;
  logic [ddly_sync_pkg::DIV_W-1:0]       cnt_d;

  // exempt outputs ignore the force entirely
  assign hold = force_low_i & ~exempt_i;
  assign half = divide_i >> 1;

  // divider count wraps at divide-1, high part first
  always_comb
  begin
    if (cnt_q + 8'h01 >= divide_i)
      cnt_d = '0;
    else
      cnt_d = cnt_q + 8'h01;
  end

  // run, hold low, then count the programmed delay before rising
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ddly_sync_pkg::CH_RUN;
      cnt_q   <= '0;
      dly_q   <= '0;
      clk_o   <= 1'b0;
    end
    else
    begin
      case (state_q)
        ddly_sync_pkg::CH_RUN:
        begin
          if (power_down_i)
          begin
            clk_o <= 1'b0;
            cnt_q <= '0;
          end
          else if (hold)
          begin
            state_q <= ddly_sync_pkg::CH_HELD;
            clk_o   <= 1'b0; // (may clip a high phase short)
          end
          else if (divide_i < 8'h02)
            clk_o <= ~clk_o;
          else
          begin
            cnt_q <= cnt_d;
            clk_o <= (cnt_d < (divide_i - half));
          end
        end
        ddly_sync_pkg::CH_HELD:
        begin
          clk_o <= 1'b0;
          if (!hold)
          begin
            // new delay count is taken only here, at the restart
            if (delay_i == '0)
            begin
              state_q <= ddly_sync_pkg::CH_RUN;
              cnt_q   <= '0;
              clk_o   <= ~power_down_i;
            end
            else
            begin
              state_q <= ddly_sync_pkg::CH_DELAY;
              dly_q   <= delay_i - 5'h01;
            end
          end
        end
        ddly_sync_pkg::CH_DELAY:
        begin
          clk_o <= 1'b0;
          if (hold)
            state_q <= ddly_sync_pkg::CH_HELD;
          else if (dly_q == '0)
          begin
            state_q <= ddly_sync_pkg::CH_RUN;
            cnt_q   <= '0;
            clk_o   <= ~power_down_i;
          end
          else
            dly_q <= dly_q - 5'h01;
        end
        default:
        begin
          state_q <= ddly_sync_pkg::CH_RUN;
          clk_o   <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: hw/ddly_sync_top.sv */
// alignment control, register file and six output channels on one AHB-Lite slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
module ddly_sync_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        ALIGN_PIN_I,
  output logic      [5:0]  CLK_OUT_O,
  output logic      [5:0]  HALF_STEP_O,
  output logic             ALIGN_BUSY_O
);

  localparam int unsigned N = ddly_sync_pkg::NUM_OUTPUTS;

  // register storage
  logic [ddly_sync_pkg::DIV_W-1:0]  divide_q    [N];
  logic [ddly_sync_pkg::DDLY_W-1:0] ddly_q      [N];
  logic [N-1:0]                     half_step_q;
  logic [N-1:0]                     exempt_q;
  logic [N-1:0]                     power_down_q;
  logic                             qual_en_q;
  logic                             fb_en_q;
  logic                             auto_q;
  logic                             pol_inv_q;
  logic [ddly_sync_pkg::SEL_W-1:0]  fb_sel_q;

  // bus data-phase bookkeeping
  logic                             wr_pend_q;
  logic [7:0]                       wr_addr_q;
  logic                             addr_ok;
  logic                             take;
  logic [7:0]                       word_addr;
  logic [31:0]                      rd_word;
  logic                             out_wr;
  logic [2:0]                       out_idx;
  logic                             auto_req_q;

  // alignment source and control
  logic                             pin_meta_q;
  logic                             pin_sync_q;
  logic                             asserted;
  logic                             asserted_q;
  logic                             req_edge;
  ddly_sync_pkg::align_state_t      state_q;
  logic [1:0]                       edge_cnt_q;
  logic [1:0]                       step_cnt_q;
  logic                             oneshot;
  logic [ddly_sync_pkg::FORCE_LAG_UNQ-1:0] lag_q;
  logic                             hold_src;
  logic                             force_low;
  logic                             qual_mode;
  logic [N-1:0]                     clk_out;
  logic                             fb_clk;
  logic                             fb_clk_q;
  logic                             fb_fall;
  logic                             abs_mode;

  // a transfer is taken when selected, NONSEQ or SEQ (HTRANS_I[1] set) and the bus is ready
  assign take      = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign word_addr = {HADDR_I[7:2], 2'b00};
  assign addr_ok   = (HADDR_I[31:8] == 24'h00_0000) & (HADDR_I[1:0] == 2'b00);
  assign out_wr    = wr_pend_q & (wr_addr_q <= ddly_sync_pkg::OUT_REG5_ADDR);
  assign out_idx   = wr_addr_q[4:2];

  // zero-wait slave: ready high once out of reset, response always okay
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      HREADYOUT_O <= 1'b0;
      HRESP_O     <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // latch the address phase of a write for the next cycle
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= take & HWRITE_I & addr_ok;
      wr_addr_q <= word_addr;
    end
  end

  // read mux; unmapped words read as zero
  always_comb
  begin
    rd_word = '0;
    if (word_addr <= ddly_sync_pkg::OUT_REG5_ADDR)
    begin
      rd_word[ddly_sync_pkg::DIV_LSB +: ddly_sync_pkg::DIV_W]   = divide_q[word_addr[4:2]];
      rd_word[ddly_sync_pkg::DDLY_LSB +: ddly_sync_pkg::DDLY_W] = ddly_q[word_addr[4:2]];
      rd_word[ddly_sync_pkg::HALF_STEP_BIT]  = half_step_q[word_addr[4:2]];
      rd_word[ddly_sync_pkg::EXEMPT_BIT]     = exempt_q[word_addr[4:2]];
      rd_word[ddly_sync_pkg::POWER_DOWN_BIT] = power_down_q[word_addr[4:2]];
    end
    else if (word_addr == ddly_sync_pkg::CONFIG_ADDR)
    begin
      rd_word[ddly_sync_pkg::QUAL_EN_BIT] = qual_en_q;
      rd_word[ddly_sync_pkg::FB_EN_BIT]   = fb_en_q;
      rd_word[ddly_sync_pkg::AUTO_BIT]    = auto_q;
      rd_word[ddly_sync_pkg::POL_INV_BIT] = pol_inv_q;
      rd_word[ddly_sync_pkg::FB_SEL_LSB +: ddly_sync_pkg::SEL_W] = fb_sel_q;
    end
    else if (word_addr == ddly_sync_pkg::STATUS_ADDR)
    begin
      rd_word[ddly_sync_pkg::ST_BUSY_BIT]  = (state_q != ddly_sync_pkg::ALIGN_IDLE);
      rd_word[ddly_sync_pkg::ST_ABS_BIT]   = abs_mode;
      rd_word[ddly_sync_pkg::ST_FORCE_BIT] = force_low;
      rd_word[ddly_sync_pkg::ST_CLK_LSB +: 6] = clk_out;
    end
  end

  // read data is ready in the data phase right after the address phase
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      HRDATA_O <= '0;
    else if (take & ~HWRITE_I & addr_ok)
      HRDATA_O <= rd_word;
    else
      HRDATA_O <= '0;
  end

  // per-output registers; half step goes straight to the output pins
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < N; i++)
      begin
        divide_q[i] <= ddly_sync_pkg::DIV_RESET;
        ddly_q[i]   <= ddly_sync_pkg::DDLY_RESET;
      end
      half_step_q  <= '0;
      exempt_q     <= '0;
      power_down_q <= '0;
    end
    else if (out_wr)
    begin
      divide_q[out_idx] <= HWDATA_I[ddly_sync_pkg::DIV_LSB +: ddly_sync_pkg::DIV_W];
      ddly_q[out_idx]   <= HWDATA_I[ddly_sync_pkg::DDLY_LSB +: ddly_sync_pkg::DDLY_W];
      half_step_q[out_idx]  <= HWDATA_I[ddly_sync_pkg::HALF_STEP_BIT];
      exempt_q[out_idx]     <= HWDATA_I[ddly_sync_pkg::EXEMPT_BIT];
      power_down_q[out_idx] <= HWDATA_I[ddly_sync_pkg::POWER_DOWN_BIT];
    end
  end

  // configuration register
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      qual_en_q <= ddly_sync_pkg::CONFIG_RESET[ddly_sync_pkg::QUAL_EN_BIT];
      fb_en_q   <= ddly_sync_pkg::CONFIG_RESET[ddly_sync_pkg::FB_EN_BIT];
      auto_q    <= ddly_sync_pkg::CONFIG_RESET[ddly_sync_pkg::AUTO_BIT];
      pol_inv_q <= ddly_sync_pkg::CONFIG_RESET[ddly_sync_pkg::POL_INV_BIT];
      fb_sel_q  <= ddly_sync_pkg::CONFIG_RESET[ddly_sync_pkg::FB_SEL_LSB +: 3];
    end
    else if (wr_pend_q & (wr_addr_q == ddly_sync_pkg::CONFIG_ADDR))
    begin
      qual_en_q <= HWDATA_I[ddly_sync_pkg::QUAL_EN_BIT];
      fb_en_q   <= HWDATA_I[ddly_sync_pkg::FB_EN_BIT];
      auto_q    <= HWDATA_I[ddly_sync_pkg::AUTO_BIT];
      pol_inv_q <= HWDATA_I[ddly_sync_pkg::POL_INV_BIT];
      fb_sel_q  <= HWDATA_I[ddly_sync_pkg::FB_SEL_LSB +: ddly_sync_pkg::SEL_W];
    end
  end

  // a write to any output register in auto mode requests an alignment
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      auto_req_q <= 1'b0;
    else
      auto_req_q <= out_wr & auto_q;
  end

  // alignment pin is asynchronous: two flops before any use
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= ALIGN_PIN_I;
      pin_sync_q <= pin_meta_q;
    end
  end

  // toggling either the pin or the polarity bit asserts the request
  assign asserted = pin_sync_q ^ pol_inv_q;
  assign req_edge = (asserted & ~asserted_q) | auto_req_q;

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      asserted_q <= 1'b0;
    else
      asserted_q <= asserted;
  end

  // qualification needs the enable, the feedback buffer and output 2 powered
  assign qual_mode = qual_en_q & fb_en_q & ~power_down_q[2];
  assign clk_out   = {CLK_OUT_O};
  assign fb_clk    = clk_out[fb_sel_q];
  assign fb_fall   = fb_clk_q & ~fb_clk;
  assign abs_mode  = exempt_q[fb_sel_q];

  // previous feedback level for falling-edge detection
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      fb_clk_q <= 1'b0;
    else
      fb_clk_q <= fb_clk;
  end

  // alignment sequencer: qualify on feedback falls, lead, then one-shot
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      state_q    <= ddly_sync_pkg::ALIGN_IDLE;
      edge_cnt_q <= '0;
      step_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ddly_sync_pkg::ALIGN_IDLE:
        begin
          edge_cnt_q <= '0;
          step_cnt_q <= '0;
          if (req_edge & qual_mode)
            state_q <= ddly_sync_pkg::ALIGN_QUAL;
          else if (auto_req_q)
            state_q <= ddly_sync_pkg::ALIGN_PULSE; // unqualified auto: bare one-shot
        end
        ddly_sync_pkg::ALIGN_QUAL:
        begin
          if (fb_fall)
          begin
            if (edge_cnt_q == 2'(ddly_sync_pkg::QUAL_EDGES - 1))
              state_q <= ddly_sync_pkg::ALIGN_LEAD;
            edge_cnt_q <= edge_cnt_q + 2'h1;
          end
        end
        ddly_sync_pkg::ALIGN_LEAD:
        begin
          // counting starts the cycle after the qualifying fall
          if (step_cnt_q == 2'(ddly_sync_pkg::LEAD_CYCLES - 1))
          begin
            state_q    <= ddly_sync_pkg::ALIGN_PULSE;
            step_cnt_q <= '0;
          end
          else
            step_cnt_q <= step_cnt_q + 2'h1;
        end
        ddly_sync_pkg::ALIGN_PULSE:
        begin
          if (step_cnt_q == 2'(ddly_sync_pkg::ONESHOT_CYCLES - 1))
          begin
            state_q    <= ddly_sync_pkg::ALIGN_IDLE;
            step_cnt_q <= '0;
          end
          else
            step_cnt_q <= step_cnt_q + 2'h1;
        end
        default:
          state_q <= ddly_sync_pkg::ALIGN_IDLE;
      endcase
    end
  end

  assign oneshot = (state_q == ddly_sync_pkg::ALIGN_PULSE);

  // unqualified mode holds for as long as the request is asserted
  assign hold_src = oneshot | (~qual_mode & asserted);

  // fixed lag line from request or one-shot to the forced-low window
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      lag_q <= '0;
    else
      lag_q <= {lag_q[ddly_sync_pkg::FORCE_LAG_UNQ-2:0], hold_src};
  end

  // qualified tap is one short: the channel flop adds the fifth cycle at the pin
  assign force_low = qual_mode ? lag_q[ddly_sync_pkg::FORCE_LAG_Q-2]
                               : lag_q[ddly_sync_pkg::FORCE_LAG_UNQ-1];

  // half step is a plain register view, no alignment needed
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      HALF_STEP_O  <= '0;
      ALIGN_BUSY_O <= 1'b0;
    end
    else
    begin
      HALF_STEP_O  <= half_step_q;
      ALIGN_BUSY_O <= (state_q != ddly_sync_pkg::ALIGN_IDLE) | force_low;
    end
  end

  // one channel per output; the qualifier is aligned too unless exempt
  for (genvar g = 0; g < N; g++)
  begin : g_chan
    out_channel u_chan (
      .clk_i        (CLOCK_I),
      .rst_n_i      (RST_N_I),
      .divide_i     (divide_q[g]),
      .delay_i      (ddly_q[g]),
      .exempt_i     (exempt_q[g]),
      .power_down_i (power_down_q[g]),
      .force_low_i  (force_low),
      .clk_o        (CLK_OUT_O[g])
    );
  end

endmodule

/* File: test/ddly_sync_chk.sv */
// port checker for the dynamic delay alignment block, bound to the top
module ddly_sync_chk (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [2:0]  HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        ALIGN_PIN_I,
  input wire logic [5:0]  CLK_OUT_O,
  input wire logic [5:0]  HALF_STEP_O,
  input wire logic        ALIGN_BUSY_O
);
  logic [7:0] a_q;
  logic       wr_q;
  logic       rd_q;
  logic [5:0] ex_q;
  logic [5:0] pd_q;
  logic [5:0] d2_q;
  logic [2:0] cf_q;
  logic [2:0] age_q;
  logic       qual_w;
  logic [5:0] run_w;
  logic       ow_w;

  // data phase flags, one cycle behind the taken address phase
  always_ff @(posedge CLOCK_I)
  begin
    wr_q <= RST_N_I & HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
    rd_q <= RST_N_I & HSEL_I & HTRANS_I[1] & HREADY_I & !HWRITE_I;
    if (HSEL_I & HTRANS_I[1] & HREADY_I)
      a_q <= HADDR_I[7:0];
  end

  // register mirror; the settle count hides the channel update lag
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      ex_q <= 6'h00;
      pd_q <= 6'h00;
      d2_q <= 6'h3F;
      cf_q <= 3'h0;
      age_q <= 3'h0;
    end
    else if (ow_w)
    begin
      ex_q[a_q[4:2]] <= HWDATA_I[ddly_sync_pkg::EXEMPT_BIT];
      pd_q[a_q[4:2]] <= HWDATA_I[ddly_sync_pkg::POWER_DOWN_BIT];
      d2_q[a_q[4:2]] <= HWDATA_I[7:0] <= 8'h02;
      age_q <= 3'h0;
    end
    else if (wr_q && a_q == ddly_sync_pkg::CONFIG_ADDR)
    begin
      cf_q <= HWDATA_I[2:0];
      age_q <= 3'h0;
    end
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
  end

  // divide-by-two exempt outputs must flip every cycle
  assign ow_w = wr_q && a_q <= ddly_sync_pkg::OUT_REG5_ADDR && a_q[1:0] == 2'h0;
  assign qual_w = cf_q[0] & cf_q[1] & !pd_q[2];
  assign run_w = ex_q & ~pd_q & d2_q;

  a_bus_okay: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $past(RST_N_I) |-> HREADYOUT_O && !HRESP_O) else $error("bus stalled or not okay");
  a_rdata_idle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !rd_q |-> HRDATA_O == 32'h0000_0000) else $error("read data outside data phase");
  a_half_step_write: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $changed(HALF_STEP_O) |-> $past(wr_q) || $past(wr_q, 2)) else $error("half step moved");
  a_pulse_min: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(ALIGN_BUSY_O) |-> ALIGN_BUSY_O [*3]) else $error("one-shot too short");
  a_qual_span: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(ALIGN_BUSY_O) && qual_w && !$past(ALIGN_BUSY_O, 3) |-> ALIGN_BUSY_O [*8])
    else $error("alignment too short");
  a_exempt_run: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    age_q == 3'h7 |-> ((CLK_OUT_O ^ $past(CLK_OUT_O)) & run_w) == run_w)
    else $error("exempt output stalled");
  a_auto_start: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ow_w && cf_q[2] && !ALIGN_BUSY_O |-> ##[1:4] ALIGN_BUSY_O) else $error("no auto start");
  a_release_low: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $fell(ALIGN_BUSY_O) && qual_w && !$past(ALIGN_BUSY_O, 4) |->
    ($past(CLK_OUT_O) & ~ex_q) == 6'h00)
    else $error("aligned output not held low");
endmodule

bind ddly_sync_top ddly_sync_chk chk_u (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .ALIGN_PIN_I(ALIGN_PIN_I), .CLK_OUT_O(CLK_OUT_O), .HALF_STEP_O(HALF_STEP_O),
  .ALIGN_BUSY_O(ALIGN_BUSY_O)
);

/* File: test/align_host.sv */
// host side of the alignment pin: one pulse per request
module align_host (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic req_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;

  // held several cycles so the two-flop sync cannot miss it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_q <= 3'h0;
    else if (req_i && cnt_q == 3'h0)
      cnt_q <= 3'h6;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end

  assign pin_o = cnt_q != 3'h0;
endmodule

/* File: test/dynamic_digital_delay_sync_tb.sv */
// self-checking bench for the dynamic delay alignment block
module dynamic_digital_delay_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        pin;
  logic        pin_req;
  logic [5:0]  clk_out;
  logic [5:0]  half_step;
  logic        busy;
  logic [31:0] rd;
  int          fail_count;
  int          cmp_count;
  int          rise[6];

  ddly_sync_top dut_u (
    .CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .ALIGN_PIN_I(pin),
    .CLK_OUT_O(clk_out), .HALF_STEP_O(half_step), .ALIGN_BUSY_O(busy)
  );

  align_host host_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(pin_req), .pin_o(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // single AHB-Lite transfer; read data taken at the end of the data phase
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic [31:0] oreg(input logic [4:0] dly, input logic ex);
    oreg = 32'h0000_0002 | (32'(dly) << ddly_sync_pkg::DDLY_LSB);
    oreg = oreg | (32'(ex) << ddly_sync_pkg::EXEMPT_BIT);
  endfunction

  task automatic wait_busy(input logic v);
    for (int n = 0; n < 300 && busy !== v; n++) @(posedge clk);
    check(busy, v);
  endtask

  task automatic pin_pulse();
    @(posedge clk);
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
  endtask

  // wait out one alignment, then note each output's first high cycle
  task automatic measure(input logic exp_abs);
    wait_busy(1'b1);
    bus(ddly_sync_pkg::STATUS_ADDR, 1'b0, 32'h0000_0000);
    check(rd[ddly_sync_pkg::ST_ABS_BIT], exp_abs);
    // sequencer and forced-low window show as two busy spells
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    for (int i = 0; i < 6; i++) rise[i] = -1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      for (int i = 0; i < 6; i++) if (rise[i] < 0 && clk_out[i] === 1'b1) rise[i] = n;
    end
  endtask

  task automatic t_reset();
    bus(8'h00, 1'b0, 32'h0000_0000);
    check(rd, 32'(ddly_sync_pkg::DIV_RESET) | (32'(ddly_sync_pkg::DDLY_RESET) << 8));
    bus(ddly_sync_pkg::CONFIG_ADDR, 1'b0, 32'h0000_0000);
    check(rd, ddly_sync_pkg::CONFIG_RESET);
    bus(8'h40, 1'b1, 32'hFFFF_FFFF);
    bus(8'h40, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask

  task automatic t_half_step();
    bus(8'h04, 1'b1, oreg(5'h05, 1'b0) | 32'h0000_2000);
    repeat (2) @(posedge clk);
    check(half_step[1], 1'b1);
    check(busy, 1'b0);
    bus(8'h04, 1'b1, oreg(5'h05, 1'b0));
    repeat (2) @(posedge clk);
    check(half_step[1], 1'b0);
  endtask

  task automatic t_absolute();
    bus(8'h00, 1'b1, oreg(5'h05, 1'b1));
    bus(8'h04, 1'b1, oreg(5'h05, 1'b1));
    bus(8'h08, 1'b1, oreg(5'h05, 1'b0));
    bus(8'h0C, 1'b1, oreg(5'h06, 1'b0));
    bus(8'h10, 1'b1, oreg(5'h06, 1'b0));
    bus(ddly_sync_pkg::CONFIG_ADDR, 1'b1, 32'h0000_0003);
    pin_pulse();
    measure(1'b1);
    check(32'(rise[4] - rise[3]), 32'h0000_0000);
    check(32'(rise[3] - rise[2]), 32'h0000_0001);
    bus(8'h10, 1'b1, oreg(5'h0A, 1'b0));
    repeat (10) @(posedge clk);
    check(busy, 1'b0);
    pin_pulse();
    measure(1'b1);
    check(32'(rise[4] - rise[3]), 32'h0000_0004);
  endtask

  task automatic t_relative();
    bus(ddly_sync_pkg::CONFIG_ADDR, 1'b1, 32'h0000_0033);
    bus(ddly_sync_pkg::CONFIG_ADDR, 1'b1, 32'h0000_003B);
    measure(1'b0);
    check(32'(rise[4] - rise[3]), 32'h0000_0004);
  endtask

  task automatic t_auto();
    bus(ddly_sync_pkg::CONFIG_ADDR, 1'b1, 32'h0000_0007);
    repeat (8) @(posedge clk);
    check(busy, 1'b0);
    bus(8'h14, 1'b1, oreg(5'h07, 1'b0));
    measure(1'b1);
    check(32'(rise[5] - rise[2]), 32'h0000_0002);
    check(half_step[0], 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard, well beyond the few hundred cycles the run needs
  initial
  begin
    #(25 * 20000);
    fail_count++;
    stop_test();
  end

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    pin_req = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_half_step();
    t_absolute();
    t_relative();
    t_auto();
    stop_test();
  end
endmodule
